// ### design/fsr_ctrl.sv
// Purpose: suspend/resume, high-performance mode and security-register
//          erase/program command handling of a serial flash
// Assumes: link pins asynchronous to sys_clk_i; serial clock at most
//          a quarter of sys_clk_i; array engine on sys_clk_i
// Notes:   program bytes are staged while the frame runs and only
//          committed by the pulse at a valid frame end
`timescale 1ns/1ps
module fsr_ctrl
    import fsr_pkg::*;
#(
    parameter int ERASE_CYCLES = SECTOR_ERASE_CYC,
    parameter int PROG_CYCLES = PAGE_PROGRAM_CYC,
    parameter int SUS_CYCLES = SUSPEND_CYC,
    parameter int FIFO_DEPTH = STAGE_DEPTH,
    parameter int TMR_W = 24
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic si_i,
    input wire logic array_start_i,
    input wire logic array_done_i,
    input wire logic [2:0] secreg_lock_bits_i,
    input wire logic secreg_wr_ready_i,
    output logic secreg_wr_valid_o,
    output logic [1:0] secreg_wr_sel_o,
    output logic [SEC_OFF_W-1:0] secreg_wr_off_o,
    output logic [7:0] secreg_wr_data_o,
    output logic secreg_commit_o,
    output logic secreg_discard_o,
    output logic secreg_erase_o,
    output logic [1:0] secreg_erase_sel_o,
    output logic secreg_overflow_o,
    output logic array_pause_o,
    output logic refused_cmd_o,
    output logic high_perf_mode_o,
    output logic write_in_progress_flag_o,
    output logic write_enable_latch_o,
    output logic suspend_flags_o
);

    generate
        if (SUS_CYCLES < 1 || PROG_CYCLES < 1 || ERASE_CYCLES < 1 ||
            ERASE_CYCLES >= 2 ** TMR_W || PROG_CYCLES >= 2 ** TMR_W ||
            SUS_CYCLES >= 2 ** TMR_W) begin : g_chk
            $error("fsr_ctrl: timer counts out of range");
        end
    endgenerate

    // ---------------------------------------------------------------
    // link pin synchronisers
    // ---------------------------------------------------------------
    logic [1:0] cs_sync_q;
    logic [1:0] sclk_sync_q;
    logic [1:0] si_sync_q;
    logic cs_old_q;
    logic sclk_old_q;

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cs_sync_q <= 2'h3;
            sclk_sync_q <= 2'h0;
            si_sync_q <= 2'h0;
            cs_old_q <= 1'b1;
            sclk_old_q <= 1'b0;
        end else begin
            cs_sync_q <= {cs_sync_q[0], cs_n_i};
            sclk_sync_q <= {sclk_sync_q[0], sclk_i};
            si_sync_q <= {si_sync_q[0], si_i};
            cs_old_q <= cs_sync_q[1];
            sclk_old_q <= sclk_sync_q[1];
        end
    end

    logic cs_rise;
    logic cs_fall;
    logic sclk_rise;
    assign cs_rise = cs_sync_q[1] && !cs_old_q;
    assign cs_fall = !cs_sync_q[1] && cs_old_q;
    assign sclk_rise = sclk_sync_q[1] && !sclk_old_q && !cs_sync_q[1];

    // ---------------------------------------------------------------
    // frame decoder
    // ---------------------------------------------------------------
    logic [6:0] shift_q;
    logic [2:0] bit_cnt_q;
    logic [10:0] byte_cnt_q;
    logic [7:0] opc_q;
    logic [23:0] addr_q;
    logic [SEC_OFF_W-1:0] off_q;
    logic byte_stb;
    logic [7:0] new_byte;

    assign byte_stb = sclk_rise && (bit_cnt_q == 3'h7);
    assign new_byte = {shift_q, si_sync_q[1]};

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            shift_q <= '0;
            bit_cnt_q <= '0;
            byte_cnt_q <= '0;
            opc_q <= '0;
            addr_q <= '0;
            off_q <= '0;
        end else if (cs_fall) begin
            bit_cnt_q <= '0;
            byte_cnt_q <= '0;
            opc_q <= '0;
        end else if (sclk_rise) begin
            shift_q <= new_byte[6:0];
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (byte_stb) begin
                if (byte_cnt_q != 11'h7FF) begin
                    byte_cnt_q <= byte_cnt_q + 11'h1;
                end
                if (byte_cnt_q == 11'h0) begin
                    opc_q <= new_byte;
                end else if (byte_cnt_q < 11'(ADDR_FRAME_BYTES)) begin
                    addr_q <= {addr_q[15:0], new_byte};
                    off_q <= {addr_q[1:0], new_byte};
                end else begin
                    // offset wraps inside the register
                    off_q <= off_q + 1'b1;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // address, lock and qualifier terms
    // ---------------------------------------------------------------
    logic [2:0] lock_q;
    logic [1:0] sel;
    logic addr_ok;
    logic sel_locked;
    logic frame_ok;
    logic opc_only;
    fsr_op_e op_q;
    logic wip_q;
    logic sus_q;
    logic wel_q;
    logic hpm_q;
    logic ovf_q;
    logic sec_ok;

    assign sel = addr_q[SEC_SEL_LSB+1:SEC_SEL_LSB];
    assign addr_ok = (addr_q[SEC_TOP_MSB:SEC_TOP_LSB] == 8'h00) &&
        (addr_q[SEC_GAP_MSB:SEC_GAP_LSB] == 2'h0) &&
        (addr_q[SEC_SEL_MSB:SEC_SEL_LSB] >= 4'h1) &&
        (addr_q[SEC_SEL_MSB:SEC_SEL_LSB] <= 4'(SEC_COUNT));
    assign sel_locked = lock_q[sel - 2'h1];
    // byte-aligned select rise only; a mid-byte rise aborts all
    assign frame_ok = cs_rise && (bit_cnt_q == 3'h0);
    assign opc_only = (byte_cnt_q == 11'(OPC_ONLY_BYTES));
    assign sec_ok = addr_ok && wel_q && !sel_locked &&
        !sus_q && (op_q == OP_IDLE) && !array_start_i;

    // lock bits only ever gain ones
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            lock_q <= LOCK_RESET;
        end else begin
            lock_q <= lock_q | secreg_lock_bits_i;
        end
    end

    logic suspend_go;
    logic resume_go;
    logic erase_go;
    logic prog_go;
    logic sec_take;

    assign suspend_go = frame_ok && opc_only && (opc_q == OPC_SUSPEND) &&
        !sus_q && wip_q && (op_q == OP_ARRAY);
    assign resume_go = frame_ok && opc_only && (opc_q == OPC_RESUME) &&
        sus_q && !wip_q;
    assign erase_go = frame_ok && (opc_q == OPC_SEC_ERASE) && sec_ok &&
        (byte_cnt_q == 11'(ADDR_FRAME_BYTES));
    assign prog_go = frame_ok && (opc_q == OPC_SEC_PROG) && sec_ok &&
        !ovf_q && (byte_cnt_q > 11'(ADDR_FRAME_BYTES));
    assign sec_take = erase_go || prog_go;

    // ---------------------------------------------------------------
    // operation sequencer: write-in-progress and suspend flags
    // ---------------------------------------------------------------
    logic [TMR_W-1:0] tmr_q;

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            op_q <= OP_IDLE;
            wip_q <= 1'b0;
            sus_q <= 1'b0;
            tmr_q <= '0;
        end else begin
            unique case (op_q)
                OP_IDLE: begin
                    if (array_start_i) begin
                        op_q <= OP_ARRAY;
                        wip_q <= 1'b1;
                    end else if (erase_go) begin
                        op_q <= OP_SEC_ERASE;
                        wip_q <= 1'b1;
                        tmr_q <= TMR_W'(ERASE_CYCLES);
                    end else if (prog_go) begin
                        op_q <= OP_SEC_PROG;
                        wip_q <= 1'b1;
                        tmr_q <= TMR_W'(PROG_CYCLES);
                    end
                end
                OP_ARRAY: begin
                    if (suspend_go) begin
                        op_q <= OP_ARRAY_SUSP;
                        sus_q <= 1'b1;
                        tmr_q <= TMR_W'(SUS_CYCLES);
                    end else if (array_done_i) begin
                        op_q <= OP_IDLE;
                        wip_q <= 1'b0;
                    end
                end
                OP_ARRAY_SUSP: begin
                    if (wip_q) begin
                        // engine winds down within the suspend time
                        tmr_q <= tmr_q - 1'b1;
                        if (tmr_q == TMR_W'(1)) begin
                            wip_q <= 1'b0;
                        end
                    end else if (resume_go) begin
                        op_q <= OP_ARRAY;
                        sus_q <= 1'b0;
                        wip_q <= 1'b1;
                    end
                end
                OP_SEC_ERASE, OP_SEC_PROG: begin
                    tmr_q <= tmr_q - 1'b1;
                    if (tmr_q == TMR_W'(1)) begin
                        op_q <= OP_IDLE;
                        wip_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // write-enable latch and high-performance mode
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wel_q <= 1'b0;
        end else if (sec_take) begin
            wel_q <= 1'b0;
        end else if (frame_ok && opc_only && !wip_q) begin
            if (opc_q == OPC_SET_WRITE_LATCH) begin
                wel_q <= 1'b1;
            end else if (opc_q == OPC_CLR_WRITE_LATCH) begin
                wel_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            hpm_q <= 1'b0;
        end else if (frame_ok && !wip_q) begin
            if (opc_q == OPC_HIGH_PERF &&
                byte_cnt_q == 11'(HPM_FRAME_BYTES)) begin
                hpm_q <= 1'b1;
            end else if (opc_only && opc_q == OPC_RELEASE) begin
                hpm_q <= 1'b0;
            end else if (opc_only && opc_q == OPC_DEEP_PD) begin
                hpm_q <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // program staging and pulses
    // ---------------------------------------------------------------
    fsr_stream_if #(.W(STAGE_W)) push_if ();
    fsr_stream_if #(.W(STAGE_W)) pop_if ();

    logic stage_byte;
    assign stage_byte = byte_stb && (opc_q == OPC_SEC_PROG) && sec_ok &&
        (byte_cnt_q >= 11'(ADDR_FRAME_BYTES)) && !ovf_q;
    assign push_if.valid = stage_byte && push_if.ready;
    assign push_if.data = {sel, off_q, new_byte};
    assign pop_if.ready = secreg_wr_ready_i;
    assign secreg_wr_valid_o = pop_if.valid;
    assign secreg_wr_sel_o = pop_if.data[STAGE_W-1 -: 2];
    assign secreg_wr_off_o = pop_if.data[8 +: SEC_OFF_W];
    assign secreg_wr_data_o = pop_if.data[7:0];

    fsr_fifo #(.W(STAGE_W), .DEPTH(FIFO_DEPTH)) u_stage (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .in_if(push_if),
        .out_if(pop_if)
    );

    logic [7:0] blk_opc;
    logic blk_hit;
    assign blk_opc = new_byte;
    assign blk_hit = (blk_opc == 8'h01) || (blk_opc == 8'h31) ||
        (blk_opc == 8'h11) || (blk_opc == 8'h20) || (blk_opc == 8'h52) ||
        (blk_opc == 8'hD8) || (blk_opc == 8'hC7) || (blk_opc == 8'h60) ||
        (blk_opc == 8'h02) || (blk_opc == 8'h32) ||
        (blk_opc == OPC_SEC_ERASE) || (blk_opc == OPC_SEC_PROG);

    // stage full cannot stall the host, so the frame is spoilt instead
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ovf_q <= 1'b0;
            secreg_commit_o <= 1'b0;
            secreg_discard_o <= 1'b0;
            secreg_erase_o <= 1'b0;
            secreg_erase_sel_o <= 2'h0;
            refused_cmd_o <= 1'b0;
        end else begin
            if (cs_fall) begin
                ovf_q <= 1'b0;
            end else if (stage_byte && !push_if.ready) begin
                ovf_q <= 1'b1;
            end
            secreg_commit_o <= prog_go;
            secreg_discard_o <= cs_rise && !prog_go &&
                (opc_q == OPC_SEC_PROG);
            secreg_erase_o <= erase_go;
            if (erase_go) begin
                secreg_erase_sel_o <= sel;
            end
            refused_cmd_o <= byte_stb && (byte_cnt_q == 11'h0) &&
                sus_q && blk_hit;
        end
    end

    assign secreg_overflow_o = ovf_q;
    assign array_pause_o = sus_q;
    assign high_perf_mode_o = hpm_q;
    assign write_in_progress_flag_o = wip_q;
    assign write_enable_latch_o = wel_q;
    assign suspend_flags_o = sus_q;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    // busy is sampled one edge after the counter drops it
    localparam int SUS_LIM = SUS_CYCLES + 1;
    localparam int RES_LIM = RESUME_CYC;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    AST_SUS_AT_ONCE: assert property (
        suspend_go |=> sus_q && array_pause_o)
        else $error("suspend flag not set after accepted suspend");
    AST_SUS_WIP_CLEARS: assert property (
        suspend_go |-> ##[1:SUS_LIM] !wip_q)
        else $error("busy flag not cleared within suspend time");
    AST_SUS_IGNORED: assert property (
        frame_ok && opc_q == OPC_SUSPEND && !suspend_go
        |=> $stable(sus_q) && $stable(op_q))
        else $error("ignored suspend changed state");
    AST_RESUME: assert property (
        resume_go |=> !sus_q ##[0:RES_LIM] wip_q)
        else $error("resume did not clear suspend and restore busy");
    AST_RESUME_IGNORED: assert property (
        frame_ok && opc_q == OPC_RESUME && !resume_go
        |=> $stable(sus_q) && $stable(wip_q))
        else $error("ignored resume changed flags");
    AST_HPM_RELEASE: assert property (
        frame_ok && opc_only && opc_q == OPC_RELEASE && !wip_q |=> !hpm_q)
        else $error("release opcode left high performance mode on");
    AST_HPM_DEEP_PD: assert property (
        frame_ok && opc_only && opc_q == OPC_DEEP_PD && !wip_q |=> !hpm_q)
        else $error("deep power-down left high performance mode on");
    AST_NO_SEC_IN_SUSP: assert property (
        sus_q |-> !sec_take && !stage_byte)
        else $error("security op accepted while suspended");
    AST_LOCK_STICKY: assert property (
        lock_q != 3'h0 |=> (lock_q & $past(lock_q)) == $past(lock_q))
        else $error("security lock bit cleared");
    AST_SEC_CYCLE: assert property (
        sec_take |=> wip_q && !wel_q && op_q != OP_IDLE)
        else $error("self-timed cycle did not start cleanly");
    AST_MIDBYTE_ABORT: assert property (
        cs_rise && bit_cnt_q != 3'h0 |=> $stable(op_q) && $stable(wel_q))
        else $error("misaligned frame end took effect");
    AST_REFUSED_KEEPS: assert property (
        cs_rise && (opc_q == OPC_SEC_ERASE || opc_q == OPC_SEC_PROG) &&
        !sec_take |=> $stable(wip_q) && $stable(sus_q) && $stable(wel_q))
        else $error("refused security op changed flags");

    COV_SUSPEND: cover property (suspend_go);
    COV_RESUME: cover property (resume_go);
    COV_ERASE: cover property (erase_go);
    COV_PROGRAM: cover property (prog_go ##1 secreg_commit_o);

endmodule

// ### design/fsr_fifo.sv
// Purpose: flip-flop FIFO for staged security-register bytes
// Assumes: depth a power of two, at least 2
// Notes:   full and empty come straight from the pointers
`timescale 1ns/1ps
module fsr_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    fsr_stream_if.cons in_if,
    fsr_stream_if.prod out_if
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
            $error("fsr_fifo: DEPTH must be a power of two >= 2");
        end
    endgenerate

    logic [W-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;
    logic full;
    logic empty;

    assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign empty = (wr_q == rd_q);
    assign in_if.ready = !full;
    assign out_if.valid = !empty;
    assign out_if.data = mem_q[rd_q[AW-1:0]];
    assign push = in_if.valid && !full;
    assign pop = out_if.ready && !empty;

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

    // storage needs no reset; empty hides stale words
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_if.data;
        end
    end

endmodule

// ### design/fsr_pkg.sv
// Purpose: shared constants of the flash suspend/resume and
//          security-register command block
// Assumes: 40 MHz block clock
// Notes:   times are in ns, cycle counts derive from them
package fsr_pkg;

    // ---------------------------------------------------------------
    // command opcodes
    // ---------------------------------------------------------------
    localparam logic [7:0] OPC_SET_WRITE_LATCH = 8'h06;
    localparam logic [7:0] OPC_CLR_WRITE_LATCH = 8'h04;
    localparam logic [7:0] OPC_HIGH_PERF = 8'hA3;
    localparam logic [7:0] OPC_RELEASE = 8'hAB;
    localparam logic [7:0] OPC_DEEP_PD = 8'hB9;
    localparam logic [7:0] OPC_SUSPEND = 8'h75;
    localparam logic [7:0] OPC_RESUME = 8'h7A;
    localparam logic [7:0] OPC_SEC_ERASE = 8'h44;
    localparam logic [7:0] OPC_SEC_PROG = 8'h42;

    // ---------------------------------------------------------------
    // frame lengths and security-register address fields
    // ---------------------------------------------------------------
    localparam int OPC_ONLY_BYTES = 1;
    localparam int HPM_FRAME_BYTES = 4;
    localparam int ADDR_FRAME_BYTES = 4;
    localparam int SEC_SIZE_BYTES = 1024;
    localparam int SEC_OFF_W = 10;
    localparam int SEC_SEL_LSB = 12;
    localparam int SEC_SEL_MSB = 15;
    localparam int SEC_GAP_LSB = 10;
    localparam int SEC_GAP_MSB = 11;
    localparam int SEC_TOP_LSB = 16;
    localparam int SEC_TOP_MSB = 23;
    localparam int SEC_COUNT = 3;
    localparam logic [2:0] LOCK_RESET = 3'h0;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int SECTOR_ERASE_TIME_NS = 45000000;
    localparam int PAGE_PROGRAM_TIME_NS = 600000;
    localparam int SUSPEND_TIME_NS = 20000;
    localparam int RESUME_TIME_NS = 200;
    localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_TIME_NS / CLK_PERIOD_NS;
    localparam int PAGE_PROGRAM_CYC = PAGE_PROGRAM_TIME_NS / CLK_PERIOD_NS;
    localparam int SUSPEND_CYC = SUSPEND_TIME_NS / CLK_PERIOD_NS;
    localparam int RESUME_CYC = RESUME_TIME_NS / CLK_PERIOD_NS;

    // staged byte: register select, byte offset, data
    localparam int STAGE_W = 2 + SEC_OFF_W + 8;
    localparam int STAGE_DEPTH = 16;

    typedef enum logic [2:0] {
        OP_IDLE,
        OP_ARRAY,
        OP_ARRAY_SUSP,
        OP_SEC_ERASE,
        OP_SEC_PROG
    } fsr_op_e;

endpackage

// ### design/fsr_stream_if.sv
// Purpose: valid/ready word stream between the block's own modules
// Assumes: one producer and one consumer on the same clock
// Notes:   word taken when valid and ready are both high
`timescale 1ns/1ps
interface fsr_stream_if #(
    parameter int W = 8
);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport prod (output valid, output data, input ready);
    modport cons (input valid, input data, output ready);
endinterface

// ### dv/fsr_host_model.sv
// Purpose: host side of the serial link, sends whole frames
// Assumes: sclk period of 8 block clocks, data taken on sclk rise
// Notes:   sclk stands low outside frames; si inverts when deselected
`timescale 1ns/1ps
module fsr_host_model (
    input wire logic sys_clk_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic si_o
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        si_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    // whole bytes only, so select rises on a byte boundary
    task automatic frame(input logic [7:0] b[$]);
        cs_n_o <= 1'b0;
        tick(4);
        foreach (b[i]) begin
            for (int k = 7; k >= 0; k--) begin
                sclk_o <= 1'b0;
                si_o <= b[i][k];
                tick(4);
                sclk_o <= 1'b1;
                tick(4);
            end
        end
        sclk_o <= 1'b0;
        tick(4);
        cs_n_o <= 1'b1;
        si_o <= ~si_o;
        // flags land 3 edges after the rise; wip of suspend not before 8
        tick(6);
    endtask
endmodule

// ### dv/tb_fsr_ctrl.sv
// Purpose: self-checking bench of the suspend and secreg command block
// Assumes: shortened self-timed counts
// Notes:   one-cycle pulses are counted, tests compare the counts
`timescale 1ns/1ps
module tb_fsr_ctrl;
    import fsr_pkg::*;
    localparam int SUS = 5;
    logic sys_clk_i, reset_i, cs_n, sclk, si, a_start, a_done, rdy;
    logic [2:0] lock;
    logic vld, commit, erase, pause, refused, high_perf_mode, write_in_progress_flag, write_enable_latch, sus;
    logic dis, ovf;
    logic [1:0] sel, er_sel;
    logic [SEC_OFF_W-1:0] off;
    logic [7:0] dat;
    int fail_count = 0;
    int total_checks = 0;
    int n_com = 0;
    int n_er = 0;
    int n_ref = 0;
    int n_dis = 0;
    fsr_ctrl #(.ERASE_CYCLES(40), .PROG_CYCLES(30), .SUS_CYCLES(SUS))
        i_fsr_ctrl (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .cs_n_i(cs_n),
        .sclk_i(sclk), .si_i(si), .array_start_i(a_start),
        .array_done_i(a_done), .secreg_lock_bits_i(lock),
        .secreg_wr_ready_i(rdy), .secreg_wr_valid_o(vld),
        .secreg_wr_sel_o(sel), .secreg_wr_off_o(off),
        .secreg_wr_data_o(dat), .secreg_commit_o(commit),
        .secreg_discard_o(dis), .secreg_erase_o(erase),
        .secreg_erase_sel_o(er_sel), .secreg_overflow_o(ovf),
        .array_pause_o(pause), .refused_cmd_o(refused),
        .high_perf_mode_o(high_perf_mode), .write_in_progress_flag_o(write_in_progress_flag),
        .write_enable_latch_o(write_enable_latch), .suspend_flags_o(sus));
    fsr_host_model i_fsr_host_model (.sys_clk_i(sys_clk_i),
        .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si));
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        n_com += int'(commit === 1'b1);
        n_er += int'(erase === 1'b1);
        n_ref += int'(refused === 1'b1);
        n_dis += int'(dis === 1'b1);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic send(input logic [7:0] b[$]);
        i_fsr_host_model.frame(b);
    endtask
    task automatic pulse_in(input bit start);
        if (start) a_start <= 1'b1; else a_done <= 1'b1;
        @(posedge sys_clk_i);
        a_start <= 1'b0;
        a_done <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 200 && write_in_progress_flag !== 1'b0; i++) @(posedge sys_clk_i);
        if (write_in_progress_flag !== 1'b0) begin
            fail_count++;
            close_out();
        end
    endtask
    task automatic t_hpm();
        send('{8'hA3, 8'h00, 8'h00, 8'h00});
        check(high_perf_mode, 1);
        send('{8'hAB});
        check(high_perf_mode, 0);
        send('{8'hA3, 8'h00, 8'h00, 8'h00});
        check(high_perf_mode, 1);
        send('{8'hB9});
        check(high_perf_mode, 0);
        $display("test hpm done");
    endtask
    task automatic t_suspend();
        int r;
        send('{8'h75});
        check({sus, write_in_progress_flag}, 2'b00);
        pulse_in(1);
        send('{8'h75});
        check({sus, pause, write_in_progress_flag}, 3'b111);
        repeat (SUS + 2) @(posedge sys_clk_i);
        check(write_in_progress_flag, 0);
        r = n_ref;
        send('{8'h44, 8'h00, 8'h10, 8'h00});
        check(n_ref, r + 1);
        send('{8'h75});
        check({sus, write_in_progress_flag, write_enable_latch}, 3'b100);
        send('{8'h7A});
        check({sus, pause, write_in_progress_flag}, 3'b001);
        send('{8'h7A});
        check({sus, write_in_progress_flag}, 2'b01);
        pulse_in(0);
        check(write_in_progress_flag, 0);
        $display("test suspend done");
    endtask
    task automatic t_secreg();
        int e;
        int c;
        int got;
        int d;
        logic [7:0] q[$];
        send('{8'h06});
        e = n_er;
        send('{8'h44, 8'h00, 8'h10, 8'h00});
        check({write_in_progress_flag, write_enable_latch, er_sel}, 4'b1001);
        check(n_er, e + 1);
        wait_idle();
        lock <= 3'h2;
        send('{8'h06});
        send('{8'h44, 8'h00, 8'h20, 8'h00});
        check({write_in_progress_flag, write_enable_latch}, 2'b01);
        send('{8'h44, 8'h00, 8'h40, 8'h00});
        check({write_in_progress_flag, write_enable_latch}, 2'b01);
        c = n_com;
        send('{8'h42, 8'h00, 8'h33, 8'hFF, 8'hA5, 8'h5A});
        check({write_in_progress_flag, write_enable_latch}, 2'b10);
        check(n_com, c + 1);
        rdy <= 1'b1;
        got = 0;
        for (int i = 0; i < 40 && got < 2; i++) begin
            @(posedge sys_clk_i);
            if (vld === 1'b1) begin
                check({sel, off, dat},
                    got ? 20'hC_005A : 20'hF_FFA5);
                got++;
            end
        end
        rdy <= 1'b0;
        check(got, 2);
        wait_idle();
        check(write_in_progress_flag, 0);
        // 17 data bytes with the store stalled: stage overflows
        d = n_dis;
        c = n_com;
        send('{8'h06});
        q = '{8'h42, 8'h00, 8'h10, 8'h00};
        repeat (17) q.push_back(8'h3C);
        send(q);
        check({write_in_progress_flag, write_enable_latch, ovf}, 3'b011);
        check(n_com, c);
        check(n_dis, d + 1);
        $display("test secreg done");
    endtask
    initial begin
        reset_i = 1'b1;
        a_start = 1'b0;
        a_done = 1'b0;
        rdy = 1'b0;
        lock = 3'h0;
        repeat (8) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        t_hpm();
        t_suspend();
        t_secreg();
        close_out();
    end
endmodule
